/* hdl/dac_control.v */
// Control register, output value register and update logic of the converter.
// Assumes a single-cycle register port and sync timer, bus clock and uart clock.
// Summary of operation
// - Bit 9 set powers down and tristates the output; clear enables.
// - Bit 8 set puts the output buffer in low-power mode.
// - Bit 7 set makes the buffer a standalone amplifier.
// - Bit 6 set bypasses the buffer, routing output straight to pin.
// - Bit 5 picks update on bus clock fall (0) or timer fall (1).
// - Bit 4 zero clears the output and the value register immediately.
// - Bit 3 selects 16-bit interpolation (1) or 12-bit normal (0).
// - Bit 2 selects interpolation clock uart clock/16 (1) or /32 (0).
// - Normal mode outputs 12 bits; interpolation outputs 16 bits.
// - Value register holds code in 27:16, extra bits 15:12, rest reserved.
//
// Added by the designer: the address-and-strobe port.
`include "dac_consts.vh"
module dac_control (
  // Clock and reset
  input  wire                clock_i,
  input  wire                rst_i,
  // Register port
  input  wire [`ADDR_W-1:0]  addr_i,
  input  wire [31:0]         wdata_i,
  input  wire                write_i,
  input  wire                read_i,
  output reg  [31:0]         rdata_o,
  // Update sources
  input  wire                bus_clock_i,
  input  wire                first_timer_i,
  input  wire                uart_base_clock_i,
  // Analog core controls
  output reg                 output_power_down_o,
  output reg                 buffer_low_power_o,
  output reg                 amplifier_reuse_mode_o,
  output reg                 buffer_skip_o,
  output reg  [1:0]          range_select_o,
  output reg                 interpolation_o,
  output reg                 interp_tick_o,
  output reg  [15:0]         converter_code_o
);
  // Software-visible registers
  reg  [15:0] converter_control;
  reg  [31:0] converter_output_value;
  reg         update_seen;
  // Divider state
  reg  [5:0]  interp_div;
  reg         uart_clock_last;
  // Next values
  reg  [31:0] next_value;
  reg  [31:0] next_rdata;
  reg  [5:0]  next_div;
  reg         next_tick;
  reg  [15:0] next_code_out;
  reg         next_seen;
  // Update sources and decode
  wire [1:0]  src_level;
  wire [1:0]  src_fall;
  wire        bus_fall;
  wire        timer_fall;
  wire        update_event;
  wire        uart_clock_rise;
  wire [5:0]  div_limit;
  wire        ctrl_wr;
  wire        val_wr;
  wire        clear_write;
  wire        clear_held;
  wire [15:0] next_control;
  wire [15:0] next_code;
  genvar      g;

  // Sources are taken as synchronous to clock_i; an asynchronous timer would need
  // a two-stage synchroniser ahead of its detector.
  assign src_level = {first_timer_i, bus_clock_i};
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_edge
      dac_edge_detect u_dac_edge_detect (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .level_i (src_level[g]),
        .fall_o  (src_fall[g])
      );
    end
  endgenerate
  assign bus_fall   = src_fall[0];
  assign timer_fall = src_fall[1];

  assign ctrl_wr      = write_i && (addr_i == `OFS_CONTROL);
  assign val_wr       = write_i && (addr_i == `OFS_VALUE);
  assign next_control = wdata_i[15:0] & `CONTROL_MASK;
  // A clear written now acts at once, before the control register holds it
  assign clear_write  = ctrl_wr && !wdata_i[`BIT_CLEAR_N];
  assign clear_held   = !converter_control[`BIT_CLEAR_N];
  assign update_event = converter_control[`BIT_UPDATE_SRC] ? timer_fall : bus_fall;
  assign div_limit    = converter_control[`BIT_INTERP_RATE] ? `DIV_FAST : `DIV_SLOW;
  assign uart_clock_rise = uart_base_clock_i & ~uart_clock_last;
  assign next_code    = converter_control[`BIT_INTERP] ?
                        converter_output_value[`CODE_HI:`EXTRA_LO] :
                        {converter_output_value[`CODE_HI:`CODE_LO], 4'h0};

  // Next output value: a clear, written now or still held, beats a value write
  always @* begin
    next_value = converter_output_value;
    if (clear_write || (clear_held && !ctrl_wr)) begin
      next_value = `VALUE_RESET;
    end else if (val_wr) begin
      next_value = wdata_i & `VALUE_MASK;
    end
  end

  // Register file
  // Writes take effect at the strobe edge; control outputs follow one cycle later
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      converter_control      <= `CONTROL_RESET;
      converter_output_value <= `VALUE_RESET;
    end else begin
      if (ctrl_wr) begin
        converter_control <= next_control;
      end
      converter_output_value <= next_value;
    end
  end

  // Read data, registered one cycle after the strobe; zero when no read is made
  always @* begin
    next_rdata = 32'h00000000;
    if (read_i) begin
      case (addr_i)
        `OFS_CONTROL: next_rdata = {16'h0000, converter_control};
        `OFS_VALUE:   next_rdata = converter_output_value;
        // Status: bit 16 is a sticky flag that an update has happened
        `OFS_STATUS:  next_rdata = {15'h0000, update_seen, converter_code_o};
        default:      next_rdata = 32'h00000000;
      endcase
    end
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h00000000;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // Divider counts uart clock rising edges and restarts whenever interpolation is off.
  // Greater-or-equal lets a rate change in mid-count wrap at once rather than run on.
  always @* begin
    next_div  = interp_div;
    next_tick = 1'b0;
    if (!converter_control[`BIT_INTERP]) begin
      next_div = 6'h00;
    end else if (uart_clock_rise) begin
      if (interp_div >= div_limit) begin
        next_div  = 6'h00;
        next_tick = 1'b1;
      end else begin
        next_div = interp_div + 6'h01;
      end
    end
  end

  // The tick is registered so that it is a clean one-cycle pulse
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      uart_clock_last <= 1'b0;
      interp_div      <= 6'h00;
      interp_tick_o   <= 1'b0;
    end else begin
      uart_clock_last <= uart_base_clock_i;
      interp_div      <= next_div;
      interp_tick_o   <= next_tick;
    end
  end

  // Next output code: a clear wins over an update that falls in the same cycle
  always @* begin
    next_code_out = converter_code_o;
    next_seen     = update_seen;
    if (clear_write || clear_held) begin
      next_code_out = 16'h0000;
    end else if (update_event) begin
      next_code_out = next_code;
      next_seen     = 1'b1;
    end
  end

  // Reset leaves the converter powered down, matching the control register reset.
  // Amplifier reuse and power down are independent; software keeps both set together.
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      output_power_down_o    <= 1'b1;
      buffer_low_power_o     <= 1'b0;
      amplifier_reuse_mode_o <= 1'b0;
      buffer_skip_o          <= 1'b0;
      range_select_o         <= 2'h0;
      interpolation_o        <= 1'b0;
    end else begin
      output_power_down_o    <= converter_control[`BIT_POWER_DOWN];
      buffer_low_power_o     <= converter_control[`BIT_BUF_LOW_POWER];
      amplifier_reuse_mode_o <= converter_control[`BIT_AMP_REUSE];
      buffer_skip_o          <= converter_control[`BIT_BUF_SKIP];
      range_select_o         <= converter_control[`RANGE_HI:`RANGE_LO];
      interpolation_o        <= converter_control[`BIT_INTERP];
    end
  end

  // Output code and update flag
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      converter_code_o <= 16'h0000;
      update_seen      <= 1'b0;
    end else begin
      converter_code_o <= next_code_out;
      update_seen      <= next_seen;
    end
  end
endmodule

/* shared/dac_consts.vh */
// Constants for the converter control block: offsets, field positions, resets.
// Assumes byte addresses on a 32-bit register port, one word per register.
`ifndef DAC_CONSTS_VH
`define DAC_CONSTS_VH
`define ADDR_W            32
`define OFS_CONTROL       32'hFFFF0600
`define OFS_VALUE         32'hFFFF0604
`define OFS_STATUS        32'hFFFF0608
`define CONTROL_RESET     16'h0200
`define CONTROL_MASK      16'h03FF
`define VALUE_RESET       32'h00000000
`define VALUE_MASK        32'h0FFFF000
`define BIT_POWER_DOWN    9
`define BIT_BUF_LOW_POWER 8
`define BIT_AMP_REUSE     7
`define BIT_BUF_SKIP      6
`define BIT_UPDATE_SRC    5
`define BIT_CLEAR_N       4
`define BIT_INTERP        3
`define BIT_INTERP_RATE   2
`define RANGE_HI          1
`define RANGE_LO          0
`define CODE_HI           27
`define CODE_LO           16
`define EXTRA_HI          15
`define EXTRA_LO          12
`define DIV_FAST          6'h0F
`define DIV_SLOW          6'h1F
`endif

/* hdl/dac_edge_detect.v */
// Falling-edge detector for the update sources.
// Assumes inputs synchronous to clock_i.
module dac_edge_detect (
  // Clock and reset
  input  wire clock_i,
  input  wire rst_i,
  // Sampled level and its falling edge
  input  wire level_i,
  output reg  fall_o
);
  reg last;
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      last   <= 1'b1;
      fall_o <= 1'b0;
    end else begin
      last   <= level_i;
      fall_o <= last & ~level_i;
    end
  end
endmodule

/* verif/dac_analog_model.sv */
// Analog core model: turns the code into a pin level.
// Assumes control levels straight from dac_control.
module dac_analog_model (
  input  wire        power_down_i,
  input  wire [15:0] code_i,
  output wire [15:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Powered down leaves the pin floating
  assign pin_o = power_down_i ? 16'hZZZZ : code_i;
endmodule

/* verif/dac_control_props.sv */
// Port checks for dac_control, bound into every instance.
// Assumes the register map of dac_consts.vh.
`include "dac_consts.vh"
module dac_control_props (
  // Clock and reset
  input wire        clock_i,
  input wire        rst_i,
  // Register port
  input wire        write_i,
  input wire        read_i,
  input wire [31:0] addr_i,
  input wire [31:0] wdata_i,
  input wire [31:0] rdata_i,
  // Analog core controls
  input wire        power_down_i,
  input wire        low_power_i,
  input wire        amp_reuse_i,
  input wire        skip_i,
  input wire [1:0]  range_i,
  input wire        interp_i,
  input wire        tick_i,
  input wire [15:0] code_i
);
  timeunit 1ns;
  timeprecision 1ps;
  wire wc;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  assign wc = write_i && (addr_i == `OFS_CONTROL);
  AST_PD: assert property (wc |-> ##2 power_down_i == $past(wdata_i[9], 2))
    else $error("power down wrong");
  AST_LP: assert property (wc |-> ##2 low_power_i == $past(wdata_i[8], 2))
    else $error("low power wrong");
  AST_AMP: assert property (wc |-> ##2 amp_reuse_i == $past(wdata_i[7], 2))
    else $error("amplifier wrong");
  AST_SKIP: assert property (wc |-> ##2 skip_i == $past(wdata_i[6], 2))
    else $error("skip wrong");
  AST_MODE: assert property (wc |-> ##2 interp_i == $past(wdata_i[3], 2))
    else $error("mode wrong");
  AST_RANGE: assert property (wc |-> ##2 range_i == $past(wdata_i[1:0], 2))
    else $error("range wrong");
  AST_HIGH: assert property (read_i && addr_i == `OFS_CONTROL |=> rdata_i[31:10] == 22'h0)
    else $error("reserved bits set");
  AST_CLEAR: assert property (wc && !wdata_i[4] |=> code_i == 16'h0000)
    else $error("clear late");
  AST_TICK: assert property (tick_i |-> interp_i)
    else $error("tick outside interpolation");
  cover property (tick_i);
  cover property (wc && !wdata_i[4]);
  cover property (code_i == 16'hABC5);
endmodule
bind dac_control dac_control_props u_props (
  .clock_i      (clock_i),
  .rst_i        (rst_i),
  .write_i      (write_i),
  .read_i       (read_i),
  .addr_i       (addr_i),
  .wdata_i      (wdata_i),
  .rdata_i      (rdata_o),
  .power_down_i (output_power_down_o),
  .low_power_i  (buffer_low_power_o),
  .amp_reuse_i  (amplifier_reuse_mode_o),
  .skip_i       (buffer_skip_o),
  .range_i      (range_select_o),
  .interp_i     (interpolation_o),
  .tick_i       (interp_tick_o),
  .code_i       (converter_code_o)
);

/* verif/dac_control_tb_top.sv */
// Bench for dac_control with the analog core model on its outputs.
// Assumes a 200 MHz clock and the map of dac_consts.vh.
`include "dac_consts.vh"
module dac_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 0, rst_i = 1, write_i = 0, read_i = 0, bus_clock_i = 1, first_timer_i = 1;
  logic uart_base_clock_i = 0, uart_on = 0;
  logic [31:0] addr_i = 0, wdata_i = 0;
  wire [31:0] rdata_o;
  wire [15:0] code, pin;
  wire [1:0] range;
  wire pd, lp, amp, skip, interp, tick;
  int bad_count = 0, tests_run = 0;
  always #2.5 clock_i = ~clock_i;
  always @(posedge clock_i) if (uart_on) uart_base_clock_i <= ~uart_base_clock_i;
  dac_control u_dac_control (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
    .bus_clock_i(bus_clock_i), .first_timer_i(first_timer_i),
    .uart_base_clock_i(uart_base_clock_i), .output_power_down_o(pd),
    .buffer_low_power_o(lp), .amplifier_reuse_mode_o(amp), .buffer_skip_o(skip),
    .range_select_o(range), .interpolation_o(interp), .interp_tick_o(tick),
    .converter_code_o(code));
  dac_analog_model u_dac_analog_model (.power_down_i(pd), .code_i(code), .pin_o(pin));
  task automatic check(string what, logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(logic [31:0] a, d);
    @(posedge clock_i);
    {write_i, addr_i, wdata_i} <= {1'b1, a, d};
    @(posedge clock_i);
    write_i <= 0;
    @(posedge clock_i);
    #1;
  endtask
  task automatic rd(string what, logic [31:0] a, exp);
    @(posedge clock_i);
    {read_i, addr_i} <= {1'b1, a};
    @(posedge clock_i);
    read_i <= 0;
    #1 check(what, rdata_o, exp);
  endtask
  // Level stays low long enough for the sampled edge to reach the code
  task automatic fall(bit timer);
    @(posedge clock_i);
    {bus_clock_i, first_timer_i} <= {timer, !timer};
    repeat (4) @(posedge clock_i);
    {bus_clock_i, first_timer_i} <= 2'b11;
    repeat (2) @(posedge clock_i);
    #1;
  endtask
  task automatic t_fields();
    logic [15:0] w [5] = '{16'hFFFF, 16'h0201, 16'h0102, 16'h0283, 16'h0048};
    foreach (w[i]) begin
      wr(`OFS_CONTROL, {16'h0000, w[i]});
      check("controls", {pd, lp, amp, skip, interp, range}, {w[i][9:6], w[i][3], w[i][1:0]});
      rd("control", `OFS_CONTROL, {16'h0000, w[i] & `CONTROL_MASK});
    end
  endtask
  task automatic t_update();
    wr(`OFS_CONTROL, 32'h0000_0010);
    wr(`OFS_VALUE, 32'hFABC_5123);
    fall(0);
    check("code", code, 16'hABC0);
    check("pin", pin, 16'hABC0);
    wr(`OFS_CONTROL, 32'h0000_0018);
    fall(0);
    check("interp code", code, 16'hABC5);
    wr(`OFS_CONTROL, 32'h0000_0030);
    wr(`OFS_VALUE, 32'h0123_4000);
    fall(0);
    check("held code", code, 16'hABC5);
    fall(1);
    check("timer code", code, 16'h1230);
    rd("status", `OFS_STATUS, 32'h0001_1230);
    wr(`OFS_CONTROL, 32'h0000_0020);
    check("cleared code", code, 16'h0000);
    rd("cleared value", `OFS_VALUE, 32'h0000_0000);
  endtask
  task automatic t_tick(logic [31:0] ctl, int exp);
    realtime t;
    wr(`OFS_CONTROL, ctl);
    uart_on = 1;
    @(posedge tick);
    t = $realtime;
    @(posedge tick);
    uart_on = 0;
    check("tick period", int'(($realtime - t) / 5.0), exp);
  endtask
  initial begin
    #20000;
    bad_count++;
    results();
  end
  task automatic t_reset();
    rd("reset control", `OFS_CONTROL, 32'h0000_0200);
    check("pin off", pin, 32'h0000_ZZZZ);
    rd("unmapped", 32'hFFFF_060C, 32'h0000_0000);
  endtask
  initial begin
    repeat (8) @(posedge clock_i);
    rst_i <= 0;
    t_reset();
    t_fields();
    t_update();
    t_tick(32'h0000_001C, 32);
    t_tick(32'h0000_0018, 64);
    results();
  end
endmodule
